// ---- dv/simm_pair_model.sv ----
// Behavioural model of the DRAM module pairs hanging on the controller's memory bus.
`default_nettype none
module simm_pair_model (
	input wire logic i_clk,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_ras_n,
	input wire logic [7:0] i_cas_n,
	input wire logic i_we_n,
	input wire logic [71:0] i_data,
	input wire logic i_edo,
	output logic [71:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [71:0] mem [int];
	logic [71:0] last_q = '0;
	logic [71:0] w;
	logic [11:0] row_q = '0;
	logic [7:0] ras_q = 8'hff;
	logic [7:0] cas_q = 8'hff;
	logic drive_q = 1'b0;
	int key;
	// Strobes are looked at mid-cycle, where the controller's registered pins have settled.
	always @(negedge i_clk) begin
		if (&ras_q && !(&i_ras_n) && &i_cas_n) row_q <= i_addr;
		key = {i_ras_n, row_q, i_addr};
		if (&cas_q && !(&i_cas_n) && !(&i_ras_n)) begin
			w = mem.exists(key) ? mem[key] : '0;
			for (int b = 0; b < 8; b++) begin
				if (!i_we_n && !i_cas_n[b]) w[8*b+:8] = i_data[8*b+:8];
			end
			if (!i_we_n) mem[key] = w;
			else begin
				last_q <= w;
				drive_q <= 1'b1;
			end
		end
		// EDO parts keep data after CAS rises; page-mode parts release it at once.
		if (i_edo ? &i_ras_n : &i_cas_n) drive_q <= 1'b0;
		ras_q <= i_ras_n;
		cas_q <= i_cas_n;
	end
	// A released bus shows the inverse, so stale data can never look valid.
	assign o_data = drive_q ? last_q : ~last_q;
endmodule : simm_pair_model
`default_nettype wire

// ---- dv/test_simm_dram_controller.sv ----
// Self-checking bench of the DRAM array controller with a module-pair model.
`default_nettype none
module test_simm_dram_controller
	import dram_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic req_valid = 1'b0;
	mem_req_type req = '0;
	logic [71:0] req_wdata = '0;
	logic ready, rsp_valid, rsp_pci, rsp_ca, we_n, oe, edo = 1'b0;
	logic [71:0] rsp_rdata, mem_in, mem_out;
	logic [11:0] mux, seen_row, seen_col;
	logic [7:0] ras_n, cas_n, seen_ras, seen_cas;
	logic [7:0] ras_q = 8'hff;
	logic [7:0] cas_q = 8'hff;
	logic [1:0] drive;
	logic [31:0] q;
	logic err, r_pci, r_ca, cbr_ok, seen_oe;
	logic [71:0] r_data;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int last_ref = 0;
	int prev_ref = 0;
	always #12.5 clk = ~clk;
	simm_dram_controller simm_dram_controller_i (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_REQ_VALID(req_valid), .I_REQ(req),
		.I_REQ_WDATA(req_wdata), .O_REQ_READY(ready), .O_RSP_VALID(rsp_valid),
		.O_RSP_PCI(rsp_pci), .O_RSP_CACHEABLE(rsp_ca), .O_RSP_RDATA(rsp_rdata),
		.O_DRAM_MUX_ADDR(mux), .O_ROW_STROBE_N(ras_n), .O_COLUMN_STROBE_N(cas_n),
		.O_MEMORY_WRITE_ENABLE_N(we_n), .I_MEM_DATA(mem_in), .O_MEM_DATA(mem_out),
		.O_MEM_DATA_OE(oe), .O_ADDR_DRIVE_STRENGTH(drive));
	simm_pair_model simm_pair_model_i (.i_clk(clk), .i_addr(mux), .i_ras_n(ras_n),
		.i_cas_n(cas_n), .i_we_n(we_n), .i_data(mem_out), .i_edo(edo), .o_data(mem_in));
	// Remember strobe events so that scenarios can judge the last DRAM cycle.
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (&ras_q && ras_n != 8'hff && ras_n != 8'h00) begin
			seen_ras <= ras_n;
			seen_row <= mux;
		end
		if (&cas_q && !(&cas_n) && !we_n) begin
			seen_cas <= cas_n;
			seen_col <= mux;
			seen_oe <= oe;
		end
		if (ras_q != 8'h00 && ras_n == 8'h00) begin
			cbr_ok <= (cas_q == 8'h00);
			prev_ref <= last_ref;
			last_ref <= cyc;
		end
		ras_q <= ras_n;
		cas_q <= cas_n;
	end
	task automatic check(input logic [71:0] s, input logic [71:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic mreq(input logic [31:0] a, input logic wr, input logic [7:0] be,
		input logic smm, input logic [71:0] wd);
		req <= '{addr: a, write: wr, byte_en: be, smm: smm};
		req_wdata <= wd;
		req_valid <= 1'b1;
		do @(negedge clk); while (ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
		do @(negedge clk); while (rsp_valid !== 1'b1);
		r_pci = rsp_pci;
		r_ca = rsp_ca;
		r_data = rsp_rdata;
		@(posedge clk);
	endtask : mreq
	task automatic t_regs;
		apb(1'b0, OFS_TIMING, '0);
		check(q, TIMING_RST);
		apb(1'b0, OFS_ATTR0, '0);
		check(q, ATTR_RST);
		apb(1'b0, 8'h60, '0);
		check(err, 1'b1);
		apb(1'b1, OFS_TIMING, 32'h2);
		apb(1'b1, OFS_EXT_CTRL, 32'h3);
		check(drive, 2'h3);
	endtask : t_regs
	// Row 0 is left empty, so the low 16 MB sit in row 1.
	task automatic t_rows;
		for (int i = 0; i < 8; i++) apb(1'b1, 8'(OFS_ROW_BOUND0 + 4 * i), i ? 32'h4 : 32'h0);
		mreq(32'h0050_1008, 1'b1, 8'h0f, 1'b0, 72'h00_8877_6655_4433_2211);
		check(r_pci, 1'b0);
		check(seen_ras, 8'hfd);
		check(seen_cas, 8'hf0);
		check(seen_oe, 1'b1);
		check({seen_row, seen_col}, 24'h101_201);
		mreq(32'h0050_1008, 1'b1, 8'hf0, 1'b0, 72'h00_ffee_ddcc_bbaa_9988);
		mreq(32'h0050_1008, 1'b0, 8'h00, 1'b0, '0);
		check(r_data[63:0], 64'hffee_ddcc_4433_2211);
		check(r_ca, 1'b1);
	endtask : t_rows
	task automatic t_route;
		apb(1'b1, OFS_CONTROL, 32'(HOLE_HIGH));
		mreq(HOLE_HI_START, 1'b0, 8'h00, 1'b0, '0);
		check(r_pci, 1'b1);
		apb(1'b1, OFS_CONTROL, 32'(HOLE_LOW));
		mreq(HOLE_LO_START, 1'b0, 8'h00, 1'b0, '0);
		check(r_pci, 1'b1);
		apb(1'b1, OFS_CONTROL, 32'h0);
		mreq(HOLE_HI_START, 1'b0, 8'h00, 1'b0, '0);
		check(r_pci, 1'b0);
		mreq(HOLE_HI_END, 1'b0, 8'h00, 1'b0, '0);
		check({r_pci, r_ca}, 2'b10);
		mreq(32'h000f_0000, 1'b0, 8'h00, 1'b0, '0);
		check(r_pci, 1'b1);
		apb(1'b1, OFS_ATTR0, 32'h7);
		mreq(32'h000f_0000, 1'b0, 8'h00, 1'b0, '0);
		check({r_pci, r_ca}, 2'b01);
		mreq(VIDEO_START, 1'b0, 8'h00, 1'b0, '0);
		check(r_pci, 1'b1);
		mreq(VIDEO_START, 1'b0, 8'h00, 1'b1, '0);
		check({r_pci, r_ca}, 2'b00);
		apb(1'b1, OFS_SYSTEM_MGMT_RAM, 32'(SM_CLOSED));
		mreq(VIDEO_START, 1'b0, 8'h00, 1'b1, '0);
		check(r_pci, 1'b1);
		apb(1'b1, OFS_SYSTEM_MGMT_RAM, 32'(SM_LOCKED));
		apb(1'b1, OFS_SYSTEM_MGMT_RAM, 32'(SM_OPENED));
		apb(1'b0, OFS_SYSTEM_MGMT_RAM, '0);
		check(q, 32'(SM_LOCKED));
		mreq(VIDEO_START, 1'b0, 8'h00, 1'b1, '0);
		check(r_pci, 1'b1);
	endtask : t_route
	// Row 1 switched to EDO must still return what page-mode cycles stored.
	task automatic t_edo;
		apb(1'b1, OFS_ROW_TYPE, 32'h2);
		apb(1'b1, OFS_CONTROL, 32'h4);
		edo <= 1'b1;
		mreq(32'h0050_1008, 1'b0, 8'h00, 1'b0, '0);
		check(r_data[63:0], 64'hffee_ddcc_4433_2211);
		// The row mux option moves the upper row bits from A24,A23 to A25,A24.
		apb(1'b1, OFS_ROW_TYPE, 32'h202);
		mreq(32'h0090_1008, 1'b1, 8'hff, 1'b0, '0);
		check(seen_row, 12'h101);
		check(seen_cas, 8'h00);
	endtask : t_edo
	// The first refresh seen may have waited for an access, so the two after it are timed.
	task automatic t_refresh;
		int n;
		int k;
		n = last_ref;
		k = 0;
		do begin
			@(negedge clk);
			if (last_ref != n) k++;
			n = last_ref;
		end while (k < 3);
		check(last_ref - prev_ref, REFRESH_CYC);
		check(cbr_ok, 1'b1);
		@(posedge clk);
	endtask : t_refresh
	task automatic tally_and_finish;
		if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_rows();
		t_route();
		t_edo();
		t_refresh();
		tally_and_finish();
	end
endmodule : test_simm_dram_controller
`default_nettype wire

// ---- hw/dram_ctl_pkg.sv ----
// Shared constants and types of the DRAM array controller.
`default_nettype none
package dram_ctl_pkg;
	localparam int CLK_NS = 25;
	localparam int REFRESH_NS = 15600;
	localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
	localparam int GRADE50_NS = 50;
	localparam int GRADE60_NS = 60;
	localparam int GRADE70_NS = 70;
	localparam int RP_NS = 40;
	localparam int CBR_RAS_NS = 100;
	localparam logic [3:0] RCD50_CYC = 4'((GRADE50_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RCD60_CYC = 4'((GRADE60_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RCD70_CYC = 4'((GRADE70_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RP_CYC = 4'((RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] CBR_RAS_CYC = 4'((CBR_RAS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] CBR_SETUP_CYC = 4'h1;
	localparam logic [3:0] CAS_EDO_CYC = 4'h1;
	localparam logic [3:0] CAS_FPM_CYC = 4'h2;
	localparam logic [3:0] SYNC_CYC = 4'h3;
	// Register byte offsets.
	localparam logic [7:0] OFS_ROW_BOUND0 = 8'h00;
	localparam logic [7:0] OFS_ROW_TYPE = 8'h20;
	localparam logic [7:0] OFS_CONTROL = 8'h24;
	localparam logic [7:0] OFS_TIMING = 8'h28;
	localparam logic [7:0] OFS_EXT_CTRL = 8'h2c;
	localparam logic [7:0] OFS_ATTR0 = 8'h30;
	localparam logic [7:0] OFS_ATTR_END = 8'h4c;
	localparam logic [7:0] OFS_SYSTEM_MGMT_RAM = 8'h4c;
	localparam logic [7:0] OFS_STATUS = 8'h50;
	// Field positions and codes.
	localparam int ATTR_RE_BIT = 0;
	localparam int ATTR_WE_BIT = 1;
	localparam int ATTR_CA_BIT = 2;
	localparam int EDO_EN_BIT = 2;
	localparam int RP_EXTRA_BIT = 2;
	localparam int CAS_SLOW_BIT = 3;
	localparam logic [1:0] HOLE_LOW = 2'h1;
	localparam logic [1:0] HOLE_HIGH = 2'h2;
	// Reset values.
	localparam logic [7:0] ROW_BOUND_RST = 8'h00;
	localparam logic [15:0] ROW_TYPE_RST = 16'h0000;
	localparam logic [2:0] CONTROL_RST = 3'h0;
	localparam logic [3:0] TIMING_RST = 4'h2;
	localparam logic [1:0] EXT_CTRL_RST = 2'h0;
	localparam logic [3:0] ATTR_RST = 4'h0;
	// Address windows.
	localparam logic [31:0] HOLE_LO_START = 32'h0008_0000;
	localparam logic [31:0] VIDEO_START = 32'h000a_0000;
	localparam logic [31:0] ATTR_START = 32'h000c_0000;
	localparam logic [31:0] HIGH_START = 32'h0010_0000;
	localparam logic [31:0] HOLE_HI_START = 32'h00f0_0000;
	localparam logic [31:0] HOLE_HI_END = 32'h0100_0000;

	typedef enum logic [1:0] {SM_ENABLED, SM_OPENED, SM_CLOSED, SM_LOCKED} system_mgmt_ram_type;
	typedef enum {S_IDLE, S_FWD, S_RAS, S_CAS, S_CAPTURE, S_PRECHARGE,
		S_CBR_SETUP, S_CBR_HOLD, S_CBR_PRECH} fsm_state_type;
	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic [7:0] byte_en;
		logic smm;
	} mem_req_type;
	typedef struct packed {
		logic to_dram;
		logic [2:0] row;
		logic cacheable;
	} route_type;
endpackage : dram_ctl_pkg
`default_nettype wire

// ---- hw/dram_refresh_timer.sv ----
// Interval timer that requests CAS-before-RAS refresh cycles.
`default_nettype none
module dram_refresh_timer
	import dram_ctl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ack,
	output logic o_pending
);
	logic [9:0] cnt_q;
	logic tick;
	assign tick = (cnt_q == 10'(REFRESH_CYC - 1));
	// Free-running interval counter.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 10'h000;
		end else begin
			cnt_q <= tick ? 10'h000 : cnt_q + 10'h001;
		end
	end
	// A tick in the acknowledge cycle wins, so no interval is lost.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pending <= 1'b0;
		end else if (tick) begin
			o_pending <= 1'b1;
		end else if (i_ack) begin
			o_pending <= 1'b0;
		end
	end
endmodule : dram_refresh_timer
`default_nettype wire

// ---- hw/dram_row_decode.sv ----
// Row boundary comparator that picks the row holding an address.
`default_nettype none
module dram_row_decode
	import dram_ctl_pkg::*;
(
	input wire logic [31:0] i_addr,
	input wire logic [7:0][7:0] i_bounds,
	output logic o_hit,
	output logic [2:0] o_row
);
	logic [7:0] unit;
	logic [7:0] hit;
	// Address in 4 MB units; anything at or above 512 MB never matches.
	assign unit = (i_addr[31:29] != 3'h0) ? 8'hff : {1'b0, i_addr[28:22]};
	// Row i owns the units from the previous top up to its own top.
	for (genvar i = 0; i < 8; i++) begin : g_row
		if (i == 0) begin : g_first
			assign hit[i] = unit < i_bounds[0];
		end else begin : g_rest
			// Equal tops give an empty range, so any fill order works.
			assign hit[i] = (unit < i_bounds[i]) && (unit >= i_bounds[i-1]);
		end
	end
	// At most one row can match with monotonic tops.
	always_comb begin
		o_row = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (hit[i]) begin
				o_row = 3'(i);
			end
		end
	end
	assign o_hit = |hit;
endmodule : dram_row_decode
`default_nettype wire

// ---- hw/simm_dram_controller.sv ----
// DRAM array controller: address routing, DRAM cycle sequencer and APB registers.
`default_nettype none
module simm_dram_controller
	import dram_ctl_pkg::*;
#(
	parameter int DATA_W = 72
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_REQ_VALID,
	input wire mem_req_type I_REQ,
	input wire logic [DATA_W-1:0] I_REQ_WDATA,
	output logic O_REQ_READY,
	output logic O_RSP_VALID,
	output logic O_RSP_PCI,
	output logic O_RSP_CACHEABLE,
	output logic [DATA_W-1:0] O_RSP_RDATA,
	output logic [11:0] O_DRAM_MUX_ADDR,
	output logic [7:0] O_ROW_STROBE_N,
	output logic [7:0] O_COLUMN_STROBE_N,
	output logic O_MEMORY_WRITE_ENABLE_N,
	input wire logic [DATA_W-1:0] I_MEM_DATA,
	output logic [DATA_W-1:0] O_MEM_DATA,
	output logic O_MEM_DATA_OE,
	output logic [1:0] O_ADDR_DRIVE_STRENGTH
);
	logic [7:0][7:0] row_boundary_q;
	logic [15:0] row_type_q;
	logic [2:0] control_q;
	logic [3:0] timing_q;
	logic [1:0] ext_ctrl_q;
	logic [6:0][3:0] attribute_map_q;
	system_mgmt_ram_type system_mgmt_ram_q;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [2:0] attr_idx;
	logic apb_wr;

	fsm_state_type state_q, state_d;
	logic [3:0] cnt_q, dur_d;
	mem_req_type req_q, cur_req;
	route_type route, route_q;
	logic [2:0] cur_row, hit_row;
	logic [DATA_W-1:0] wdata_q, rdata_q;
	logic [DATA_W-1:0] sync1_q, sync2_q, sync3_q;
	logic accept, row_hit, ref_pending, ref_ack, edo_row;
	logic in_hole, is_video, is_attr, attr_ok, system_mgmt_ram_ok;
	logic [2:0] region;
	logic [3:0] attr;
	logic [3:0] rcd_cyc, cas_cyc, rp_cyc;
	logic [11:0] row_addr, col_addr;
	logic rsp_valid_q;

	// APB answers in the access phase with no wait states.
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~rd_ok;
	assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE & rd_ok;
	assign attr_idx = 3'((I_PADDR - OFS_ATTR0) >> 2);

	// Register read mux; misaligned or unmapped addresses are refused.
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0000_0000;
		if (I_PADDR[1:0] != 2'h0) begin
			rd_ok = 1'b0;
		end else if (I_PADDR < OFS_ROW_TYPE) begin
			rd_data = {24'h0, row_boundary_q[I_PADDR[4:2]]};
		end else if (I_PADDR == OFS_ROW_TYPE) begin
			rd_data = {16'h0, row_type_q};
		end else if (I_PADDR == OFS_CONTROL) begin
			rd_data = {29'h0, control_q};
		end else if (I_PADDR == OFS_TIMING) begin
			rd_data = {28'h0, timing_q};
		end else if (I_PADDR == OFS_EXT_CTRL) begin
			rd_data = {30'h0, ext_ctrl_q};
		end else if (I_PADDR >= OFS_ATTR0 && I_PADDR < OFS_ATTR_END) begin
			rd_data = {28'h0, attribute_map_q[attr_idx]};
		end else if (I_PADDR == OFS_SYSTEM_MGMT_RAM) begin
			rd_data = {30'h0, system_mgmt_ram_q};
		end else if (I_PADDR == OFS_STATUS) begin
			rd_data = {27'h0, route_q.row, ref_pending, state_q != S_IDLE};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read data is latched in the setup phase and held through access.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE) begin
			O_PRDATA <= rd_data;
		end
	end

	// Configuration registers; a locked management RAM state sticks until reset.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			row_boundary_q <= {8{ROW_BOUND_RST}};
			row_type_q <= ROW_TYPE_RST;
			control_q <= CONTROL_RST;
			timing_q <= TIMING_RST;
			ext_ctrl_q <= EXT_CTRL_RST;
			attribute_map_q <= {7{ATTR_RST}};
			system_mgmt_ram_q <= SM_ENABLED;
		end else if (apb_wr) begin
			if (I_PADDR < OFS_ROW_TYPE) begin
				row_boundary_q[I_PADDR[4:2]] <= I_PWDATA[7:0];
			end else if (I_PADDR == OFS_ROW_TYPE) begin
				row_type_q <= I_PWDATA[15:0];
			end else if (I_PADDR == OFS_CONTROL) begin
				control_q <= I_PWDATA[2:0];
			end else if (I_PADDR == OFS_TIMING) begin
				timing_q <= I_PWDATA[3:0];
			end else if (I_PADDR == OFS_EXT_CTRL) begin
				ext_ctrl_q <= I_PWDATA[1:0];
			end else if (I_PADDR >= OFS_ATTR0 && I_PADDR < OFS_ATTR_END) begin
				attribute_map_q[attr_idx] <= I_PWDATA[3:0];
			end else if (I_PADDR == OFS_SYSTEM_MGMT_RAM && system_mgmt_ram_q != SM_LOCKED) begin
				system_mgmt_ram_q <= system_mgmt_ram_type'(I_PWDATA[1:0]);
			end
		end
	end

	// The address buffers take their strength straight from the register.
	assign O_ADDR_DRIVE_STRENGTH = ext_ctrl_q;

	dram_row_decode u_row_decode (
		.i_addr(I_REQ.addr),
		.i_bounds(row_boundary_q),
		.o_hit(row_hit),
		.o_row(hit_row)
	);

	dram_refresh_timer u_refresh (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.i_ack(ref_ack),
		.o_pending(ref_pending)
	);

	// Address windows below 1 MB and the optional hole.
	always_comb begin
		is_video = I_REQ.addr >= VIDEO_START && I_REQ.addr < ATTR_START;
		is_attr = I_REQ.addr >= ATTR_START && I_REQ.addr < HIGH_START;
		case (control_q[1:0])
			HOLE_LOW: in_hole = I_REQ.addr >= HOLE_LO_START && I_REQ.addr < VIDEO_START;
			HOLE_HIGH: in_hole = I_REQ.addr >= HOLE_HI_START && I_REQ.addr < HOLE_HI_END;
			default: in_hole = 1'b0;
		endcase
	end

	// F0000 to FFFFF is region 0; C0000 to EFFFF is six 32 KB regions.
	assign region = (I_REQ.addr[19:16] == 4'hf) ? 3'h0 : 3'h1 + I_REQ.addr[17:15];
	assign attr = attribute_map_q[region];
	assign attr_ok = I_REQ.write ? attr[ATTR_WE_BIT] : attr[ATTR_RE_BIT];
	// Management RAM shares the video window with the frame buffer.
	assign system_mgmt_ram_ok = (system_mgmt_ram_q == SM_OPENED) || (system_mgmt_ram_q == SM_ENABLED && I_REQ.smm);

	// Anything not claimed here goes to PCI, and the lost DRAM is not remapped.
	always_comb begin
		route.to_dram = row_hit && !in_hole;
		route.cacheable = 1'b1;
		route.row = hit_row;
		if (is_video) begin
			route.to_dram = route.to_dram && system_mgmt_ram_ok;
			route.cacheable = 1'b0;
		end else if (is_attr) begin
			route.to_dram = route.to_dram && attr_ok;
			route.cacheable = attr[ATTR_CA_BIT];
		end
		route.cacheable = route.cacheable && route.to_dram;
	end

	// Refresh has priority over a new request.
	assign O_REQ_READY = (state_q == S_IDLE) && !ref_pending;
	assign accept = I_REQ_VALID && O_REQ_READY;
	assign ref_ack = (state_q == S_IDLE) && ref_pending;
	assign cur_req = (state_q == S_IDLE) ? I_REQ : req_q;
	assign cur_row = (state_q == S_IDLE) ? route.row : route_q.row;
	assign edo_row = control_q[EDO_EN_BIT] && row_type_q[cur_row];

	// Cycle counts; timing is array-wide so it must suit the slowest part.
	always_comb begin
		case (timing_q[1:0])
			2'h0: rcd_cyc = RCD50_CYC;
			2'h1: rcd_cyc = RCD60_CYC;
			default: rcd_cyc = RCD70_CYC;
		endcase
		cas_cyc = (edo_row ? CAS_EDO_CYC : CAS_FPM_CYC) + {3'h0, timing_q[CAS_SLOW_BIT]};
		rp_cyc = RP_CYC + {3'h0, timing_q[RP_EXTRA_BIT]};
	end

	// Sequencer next state and the length of the state entered.
	always_comb begin
		state_d = state_q;
		dur_d = 4'h1;
		case (state_q)
			S_IDLE: begin
				if (ref_pending) begin
					state_d = S_CBR_SETUP;
					dur_d = CBR_SETUP_CYC;
				end else if (accept) begin
					state_d = route.to_dram ? S_RAS : S_FWD;
					dur_d = rcd_cyc;
				end
			end
			S_FWD: state_d = S_IDLE;
			S_RAS: begin
				if (cnt_q == 4'h0) begin
					state_d = S_CAS;
					dur_d = cas_cyc;
				end
			end
			S_CAS: begin
				if (cnt_q == 4'h0) begin
					state_d = req_q.write ? S_PRECHARGE : S_CAPTURE;
					dur_d = req_q.write ? rp_cyc : SYNC_CYC;
				end
			end
			S_CAPTURE: begin
				if (cnt_q == 4'h0 && sync2_q == sync3_q) begin
					state_d = S_PRECHARGE;
					dur_d = rp_cyc;
				end
			end
			S_PRECHARGE: if (cnt_q == 4'h0) state_d = S_IDLE;
			S_CBR_SETUP: begin
				if (cnt_q == 4'h0) begin
					state_d = S_CBR_HOLD;
					dur_d = CBR_RAS_CYC;
				end
			end
			S_CBR_HOLD: begin
				if (cnt_q == 4'h0) begin
					state_d = S_CBR_PRECH;
					dur_d = rp_cyc;
				end
			end
			S_CBR_PRECH: if (cnt_q == 4'h0) state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	// State register and dwell counter, reloaded on every state change.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (state_d != state_q) begin
				cnt_q <= dur_d - 4'h1;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end

	// The accepted request and its routing are held for the whole cycle.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			req_q <= '0;
			route_q <= '0;
			wdata_q <= '0;
		end else if (accept) begin
			req_q <= I_REQ;
			route_q <= route;
			wdata_q <= I_REQ_WDATA;
		end
	end

	// Fixed low row and column bits; the upper two row bits follow the row option.
	assign row_addr = row_type_q[8 + cur_row] ? {cur_req.addr[25:24], cur_req.addr[21:12]}
		: {cur_req.addr[24:23], cur_req.addr[21:12]};
	assign col_addr = {cur_req.addr[26], cur_req.addr[24], cur_req.addr[22],
		cur_req.addr[11:3]};

	// DRAM pins follow the next state so they change with it, glitch free.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_DRAM_MUX_ADDR <= 12'h000;
			O_ROW_STROBE_N <= 8'hff;
			O_COLUMN_STROBE_N <= 8'hff;
			O_MEMORY_WRITE_ENABLE_N <= 1'b1;
			O_MEM_DATA_OE <= 1'b0;
			O_MEM_DATA <= '0;
		end else begin
			O_ROW_STROBE_N <= 8'hff;
			O_COLUMN_STROBE_N <= 8'hff;
			O_MEMORY_WRITE_ENABLE_N <= 1'b1;
			O_MEM_DATA_OE <= 1'b0;
			O_MEM_DATA <= wdata_q;
			case (state_d)
				S_RAS: begin
					O_ROW_STROBE_N <= ~(8'h01 << cur_row);
					O_DRAM_MUX_ADDR <= row_addr;
					O_MEM_DATA_OE <= cur_req.write;
				end
				S_CAS: begin
					O_ROW_STROBE_N <= ~(8'h01 << cur_row);
					O_DRAM_MUX_ADDR <= col_addr;
					O_COLUMN_STROBE_N <= cur_req.write ? ~cur_req.byte_en : 8'h00;
					O_MEMORY_WRITE_ENABLE_N <= ~cur_req.write;
					O_MEM_DATA_OE <= cur_req.write;
				end
				S_CAPTURE: begin
					O_ROW_STROBE_N <= ~(8'h01 << cur_row);
					// EDO keeps data valid after the column strobe rises.
					O_COLUMN_STROBE_N <= edo_row ? 8'hff : 8'h00;
				end
				S_CBR_SETUP: O_COLUMN_STROBE_N <= 8'h00;
				S_CBR_HOLD: begin
					O_COLUMN_STROBE_N <= 8'h00;
					O_ROW_STROBE_N <= 8'h00;
				end
				default: O_ROW_STROBE_N <= 8'hff;
			endcase
		end
	end

	// Memory data come from pins, so they cross three flops before use.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= I_MEM_DATA;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Read data are taken once the last two sync stages agree.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			rdata_q <= '0;
		end else if (state_q == S_CAPTURE && state_d == S_PRECHARGE) begin
			rdata_q <= sync3_q;
		end
	end

	// One response pulse per request, for forwarded and DRAM cycles alike.
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			rsp_valid_q <= 1'b0;
		end else begin
			rsp_valid_q <= (state_q == S_FWD) ||
				(state_q != S_PRECHARGE && state_q != S_IDLE && state_d == S_PRECHARGE);
		end
	end
	assign O_RSP_VALID = rsp_valid_q;
	assign O_RSP_PCI = rsp_valid_q && !route_q.to_dram;
	assign O_RSP_CACHEABLE = rsp_valid_q && route_q.cacheable;
	assign O_RSP_RDATA = rdata_q;

	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);

	a_row_single: assert property ($countones(~O_ROW_STROBE_N) <= 1 || state_q == S_CBR_HOLD)
		else $error("more than one row strobe active");
	a_cbr_cas_first: assert property ($fell(O_ROW_STROBE_N[0]) && state_q == S_CBR_HOLD
		|-> $past(O_COLUMN_STROBE_N) == 8'h00)
		else $error("refresh row strobe before column strobe");
	a_refresh_served: assert property ($rose(ref_pending) |-> ##[1:40] state_q == S_CBR_SETUP)
		else $error("refresh not started in time");
	a_write_lanes: assert property (state_q == S_CAS && req_q.write
		|-> O_COLUMN_STROBE_N == ~req_q.byte_en && !O_MEMORY_WRITE_ENABLE_N)
		else $error("write strobes do not match byte enables");
	a_col_address: assert property (state_q == S_CAS |-> O_DRAM_MUX_ADDR[8:0] == req_q.addr[11:3])
		else $error("column address bits wrong");
	a_unclaimed_pci: assert property (accept && !route.to_dram
		|=> state_q == S_FWD ##1 O_RSP_VALID && O_RSP_PCI && !O_RSP_CACHEABLE)
		else $error("unclaimed access not forwarded");
	a_hole_pci: assert property (accept && in_hole |=> state_q == S_FWD)
		else $error("hole access reached DRAM");
	a_edo_release: assert property (state_q == S_CAPTURE && edo_row
		|-> O_COLUMN_STROBE_N == 8'hff)
		else $error("EDO row holds column strobe in capture");
	a_capture_bound: assert property ($rose(state_q == S_CAPTURE) |-> ##[3:8] state_q == S_PRECHARGE)
		else $error("read capture did not finish");
	a_system_mgmt_ram_locked: assert property (system_mgmt_ram_q == SM_LOCKED |=> system_mgmt_ram_q == SM_LOCKED)
		else $error("locked management RAM state changed");

	c_read: cover property (state_q == S_CAPTURE ##[1:8] O_RSP_VALID);
	c_write: cover property (state_q == S_CAS && req_q.write);
	c_refresh: cover property (state_q == S_CBR_HOLD);
	c_forward: cover property (O_RSP_VALID && O_RSP_PCI);
endmodule : simm_dram_controller
`default_nettype wire
